// ==== verilog/mpc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mpc_defs.svh"
module mpc_regs (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Three-wire serial port
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  // Decoded configuration fields
  output mpc_pkg::mpc_cfg_s cfg_out
);
  import mpc_pkg::*;

  // State and its next value
  mpc_state_s st_q;
  mpc_state_s st_d;

  // Address decode: hit flag plus storage index
  function automatic logic [4:0] addr_dec(input logic [6:0] a);
    case (a)
      `MPC_A_OSC: addr_dec = {1'b1, MPC_I_OSC};
      `MPC_A_BALUN: addr_dec = {1'b1, MPC_I_BALUN};
      `MPC_A_LIN: addr_dec = {1'b1, MPC_I_LIN};
      `MPC_A_MODA: addr_dec = {1'b1, MPC_I_MODA};
      `MPC_A_NULL: addr_dec = {1'b1, MPC_I_NULL};
      `MPC_A_PUMP: addr_dec = {1'b1, MPC_I_PUMP};
      `MPC_A_DITHA: addr_dec = {1'b1, MPC_I_DITHA};
      `MPC_A_DITHV: addr_dec = {1'b1, MPC_I_DITHV};
      `MPC_A_BAND: addr_dec = {1'b1, MPC_I_BAND};
      `MPC_A_INT: addr_dec = {1'b1, MPC_I_INT};
      default: addr_dec = 5'h00; // Unmapped
    endcase
  endfunction : addr_dec

  // Writable bits of each register
  function automatic logic [15:0] reg_mask(input logic [3:0] i);
    case (i)
      MPC_I_OSC: reg_mask = `MPC_M_OSC;
      MPC_I_BALUN: reg_mask = `MPC_M_BALUN;
      MPC_I_LIN: reg_mask = `MPC_M_LIN;
      MPC_I_MODA: reg_mask = `MPC_M_MODA;
      MPC_I_NULL: reg_mask = `MPC_M_NULL;
      MPC_I_PUMP: reg_mask = `MPC_M_PUMP;
      MPC_I_DITHA: reg_mask = `MPC_M_DITHA;
      MPC_I_DITHV: reg_mask = `MPC_M_DITHV;
      MPC_I_BAND: reg_mask = `MPC_M_BAND;
      MPC_I_INT: reg_mask = `MPC_M_INT;
      default: reg_mask = 16'h0000;
    endcase
  endfunction : reg_mask

  // Reset value of each register
  function automatic logic [15:0] reg_rst(input logic [3:0] i);
    case (i)
      MPC_I_OSC: reg_rst = `MPC_R_OSC;
      MPC_I_BALUN: reg_rst = `MPC_R_BALUN;
      MPC_I_LIN: reg_rst = `MPC_R_LIN;
      MPC_I_MODA: reg_rst = `MPC_R_MODA;
      MPC_I_NULL: reg_rst = `MPC_R_NULL;
      MPC_I_PUMP: reg_rst = `MPC_R_PUMP;
      MPC_I_DITHA: reg_rst = `MPC_R_DITHA;
      MPC_I_DITHV: reg_rst = `MPC_R_DITHV;
      MPC_I_BAND: reg_rst = `MPC_R_BAND;
      MPC_I_INT: reg_rst = `MPC_R_INT;
      default: reg_rst = 16'h0000;
    endcase
  endfunction : reg_rst

  // True when no register holds a bit outside its mask
  function automatic logic regs_clean(input logic [9:0][15:0] r);
    regs_clean = 1'b1;
    for (int i = 0; i < 10; i++) begin
      if ((r[i] & ~reg_mask(4'(i))) != 16'h0000) begin
        regs_clean = 1'b0;
      end
    end
  endfunction : regs_clean

  // Edge detection on the synchronised clock, second stage only
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_bit;
  logic [4:0] dec;
  logic [15:0] wr_word;
  logic wr_fire;
  assign sclk_rise = st_q.sclk_s[1] & ~st_q.sclk_p;
  assign sclk_fall = ~st_q.sclk_s[1] & st_q.sclk_p;
  assign sdi_bit = st_q.sdi_s[1];
  assign dec = addr_dec(st_q.addr);
  assign wr_word = {st_q.shift[14:0], sdi_bit};
  // Last data bit of a write frame to a mapped address
  assign wr_fire = ~st_q.cs_s[1] & sclk_rise & ~st_q.rd & dec[4] &
                   (st_q.cnt == `MPC_LAST_BIT);

  // Next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    if (srst_in) begin
      // Registers take their reset values, port goes idle
      for (int i = 0; i < 10; i++) begin
        st_d.regs[i] = reg_rst(4'(i));
      end
      st_d.sclk_s = 2'h0;
      st_d.cs_s = 2'h3;
      st_d.sdi_s = 2'h0;
      st_d.sclk_p = 1'b0;
      st_d.cnt = 5'h00;
      st_d.rd = 1'b0;
      st_d.addr = 7'h00;
      st_d.shift = 16'h0000;
      st_d.sdo = 1'b0;
      st_d.oe = 1'b0;
    end else if (ce_in) begin
      // Pins pass two flip-flops before any logic reads them
      st_d.sclk_s = {st_q.sclk_s[0], spi_sclk_in};
      st_d.cs_s = {st_q.cs_s[0], spi_cs_n_in};
      st_d.sdi_s = {st_q.sdi_s[0], sdio_in};
      st_d.sclk_p = st_q.sclk_s[1];
      if (st_q.cs_s[1]) begin
        // Deselected: frame aborted, line released
        st_d.cnt = 5'h00;
        st_d.oe = 1'b0;
      end else if (sclk_rise) begin
        // Sample one bit from the host
        if (st_q.cnt == 5'h00) begin
          st_d.rd = sdi_bit;
        end else if (st_q.cnt < `MPC_DATA_START) begin
          st_d.addr = {st_q.addr[5:0], sdi_bit};
        end else if (!st_q.rd && st_q.cnt < `MPC_FRAME_BITS) begin
          st_d.shift = wr_word;
        end
        // Commit the write, masking unassigned bits
        if (wr_fire) begin
          st_d.regs[dec[3:0]] = wr_word & reg_mask(dec[3:0]);
        end
        // Bits past the frame are ignored
        if (st_q.cnt != `MPC_FRAME_BITS) begin
          st_d.cnt = st_q.cnt + 5'd1;
        end
      end else if (sclk_fall && st_q.rd) begin
        // Drive read data on falling edges, MSB first
        if (st_q.cnt == `MPC_DATA_START) begin
          // Unmapped addresses read as zero
          if (dec[4]) begin
            st_d.sdo = st_q.regs[dec[3:0]][15];
            st_d.shift = {st_q.regs[dec[3:0]][14:0], 1'b0};
          end else begin
            st_d.sdo = 1'b0;
            st_d.shift = 16'h0000;
          end
          st_d.oe = 1'b1;
        end else if (st_q.cnt > `MPC_DATA_START &&
                     st_q.cnt < `MPC_FRAME_BITS) begin
          st_d.sdo = st_q.shift[15];
          st_d.shift = {st_q.shift[14:0], 1'b0};
        end else if (st_q.cnt == `MPC_FRAME_BITS) begin
          // Release the line after the last data bit
          st_d.oe = 1'b0;
        end
      end
    end
  end

  // Single state register
  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  // Serial output straight from flip-flops
  assign sdio_out = st_q.sdo;
  assign sdio_oe_out = st_q.oe;

  // Field slices of the register flip-flops
  assign cfg_out.osc_core_select = st_q.regs[MPC_I_OSC][2:0];
  assign cfg_out.balun_out_cap = st_q.regs[MPC_I_BALUN][7:4];
  assign cfg_out.balun_in_cap = st_q.regs[MPC_I_BALUN][3:0];
  assign cfg_out.linearizer_res_select =
    st_q.regs[MPC_I_LIN][12:6];
  assign cfg_out.linearizer_cap_select =
    st_q.regs[MPC_I_LIN][5:0];
  assign cfg_out.modulator_bleed_current = st_q.regs[MPC_I_MODA][14:12];
  assign cfg_out.q_polarity_switch =
    st_q.regs[MPC_I_MODA][11:10];
  assign cfg_out.i_polarity_switch = st_q.regs[MPC_I_MODA][9:8];
  assign cfg_out.q_sideband_null = st_q.regs[MPC_I_MODA][7:4];
  assign cfg_out.i_sideband_null = st_q.regs[MPC_I_MODA][3:0];
  // Sign in bit 7, magnitude in 5 uA steps below it
  assign cfg_out.i_carrier_null = st_q.regs[MPC_I_NULL][15:8];
  assign cfg_out.q_carrier_null = st_q.regs[MPC_I_NULL][7:0];
  assign cfg_out.antibacklash_delay = st_q.regs[MPC_I_PUMP][6:5];
  assign cfg_out.pump_control = st_q.regs[MPC_I_PUMP][4:2];
  assign cfg_out.detector_edge_select =
    st_q.regs[MPC_I_PUMP][1:0];
  assign cfg_out.dither_enable = st_q.regs[MPC_I_DITHA][3];
  assign cfg_out.dither_magnitude = st_q.regs[MPC_I_DITHA][2:1];
  assign cfg_out.dither_value_bit = st_q.regs[MPC_I_DITHA][0];
  assign cfg_out.dither_value = st_q.regs[MPC_I_DITHV];
  assign cfg_out.tuning_voltage_source =
    st_q.regs[MPC_I_BAND][9:8];
  assign cfg_out.osc_band_source = st_q.regs[MPC_I_BAND][7];
  assign cfg_out.osc_band_select = st_q.regs[MPC_I_BAND][6:0];
  assign cfg_out.internal_set_hi = st_q.regs[MPC_I_INT][13:9];
  assign cfg_out.internal_set_lo = st_q.regs[MPC_I_INT][8:0];

  // Checks on the register file and serial port
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // Helper: reset was applied with the clock enabled.
  // A sequence keeps the sampled-value calls out of plain logic.
  sequence rst_taken;
    $fell(srst_in) && $past(ce_in);
  endsequence

  a_core_sel_reset: assert property (
    rst_taken |-> cfg_out.osc_core_select == 3'h3)
    else $error("core select not 3 after reset");
  a_balun_reset: assert property (
    rst_taken |-> st_q.regs[MPC_I_BALUN] == 16'h0000)
    else $error("balun register not zero after reset");
  a_lin_reset: assert property (
    rst_taken |-> cfg_out.linearizer_res_select == 7'h44 &&
                  cfg_out.linearizer_cap_select == 6'h01)
    else $error("linearizer fields wrong after reset");
  a_pump_reset: assert property (
    rst_taken |-> st_q.regs[MPC_I_PUMP] == 16'h0010)
    else $error("pump register not 0010 after reset");
  a_dither_reset: assert property (
    rst_taken |-> st_q.regs[MPC_I_DITHA] == 16'h000E &&
                  cfg_out.dither_magnitude == 2'h3)
    else $error("dither register not 000E after reset");
  a_modctl_reset: assert property (
    rst_taken |-> st_q.regs[MPC_I_MODA] == 16'h0900)
    else $error("modulator register not 0900 after reset");
  a_internal_reset: assert property (
    rst_taken |-> cfg_out.internal_set_hi == 5'h0B &&
                  cfg_out.internal_set_lo == 9'h0BD)
    else $error("internal settings wrong after reset");
  a_reserved_zero: assert property (
    ##1 regs_clean(st_q.regs))
    else $error("unassigned register bit is set");
  a_write_commit: assert property (
    wr_fire && ce_in |=>
      st_q.regs[$past(dec[3:0])] ==
      ($past(wr_word) & reg_mask($past(dec[3:0]))))
    else $error("write not committed");
  a_dither_word: assert property (
    wr_fire && ce_in && dec[3:0] == MPC_I_DITHV |=>
      cfg_out.dither_value == $past(wr_word))
    else $error("dither word not stored whole");
  a_release_line: assert property (
    st_q.cs_s[1] && ce_in |=> !sdio_oe_out)
    else $error("line driven while deselected");
  a_read_drive: assert property (
    ce_in && !st_q.cs_s[1] && sclk_fall && st_q.rd && dec[4] &&
    st_q.cnt == `MPC_DATA_START |=>
      sdio_oe_out && sdio_out == $past(st_q.regs[dec[3:0]][15]))
    else $error("read data not driven");

  c_write: cover property (wr_fire && ce_in);
  c_read: cover property (sclk_fall && st_q.rd && dec[4] &&
                          st_q.cnt == `MPC_DATA_START);
  c_unmapped: cover property (sclk_fall && st_q.rd && !dec[4] &&
                              st_q.cnt == `MPC_DATA_START);
endmodule : mpc_regs
`default_nettype wire

// ==== verilog/mpc_defs.svh ====
// How it works
// - Core select bits 2..0, reset 3, 100 external
// - Balun output capacitance bits 7..4, reset zero
// - Balun input capacitance bits 3..0, reset zero
// - Linearizer resistor select bits 12..6, reset 44h
// - Linearizer capacitor select bits 5..0, reset 1
// - Q polarity bits 11..10, reset 2
// - I polarity bits 9..8, reset 1
// - Sideband null codes Q 7..4, I 3..0
// - I carrier null bits 15..8, sign-magnitude
// - Q carrier null bits 7..0, sign-magnitude
// - Pump control bits 4..2, reset 4
// - Detector edge select bits 1..0, reset zero
// - Tuning voltage source bits 9..8, reset zero
// - Internal settings fields reset 0Bh and 0BDh
// - Detector/pump register reads 0010h after reset
// - First dither register reads 000Eh after reset
// - Modulator control register reads 0900h after reset
// - Second dither register full 16 bits, reset zero
`ifndef MPC_DEFS_SVH
`define MPC_DEFS_SVH

// Serial frame: read flag, 7 address bits, 16 data bits
`define MPC_FRAME_BITS 5'd24
`define MPC_DATA_START 5'd8
`define MPC_LAST_BIT 5'd23

// Register addresses
`define MPC_A_OSC 7'h22
`define MPC_A_BALUN 7'h30
`define MPC_A_LIN 7'h31
`define MPC_A_MODA 7'h32
`define MPC_A_NULL 7'h33
`define MPC_A_PUMP 7'h40
`define MPC_A_DITHA 7'h42
`define MPC_A_DITHV 7'h43
`define MPC_A_BAND 7'h45
`define MPC_A_INT 7'h49

// Writable bit masks
`define MPC_M_OSC 16'h0007
`define MPC_M_BALUN 16'h00FF
`define MPC_M_LIN 16'h1FFF
`define MPC_M_MODA 16'h7FFF
`define MPC_M_NULL 16'hFFFF
`define MPC_M_PUMP 16'h007F
`define MPC_M_DITHA 16'h000F
`define MPC_M_DITHV 16'hFFFF
`define MPC_M_BAND 16'h03FF
`define MPC_M_INT 16'h3FFF

// Reset values
`define MPC_R_OSC 16'h0003
`define MPC_R_BALUN 16'h0000
`define MPC_R_LIN 16'h1101
`define MPC_R_MODA 16'h0900
`define MPC_R_NULL 16'h0000
`define MPC_R_PUMP 16'h0010
`define MPC_R_DITHA 16'h000E
`define MPC_R_DITHV 16'h0000
`define MPC_R_BAND 16'h0000
`define MPC_R_INT 16'h16BD

`endif

// ==== verilog/mpc_pkg.sv ====
`default_nettype none
package mpc_pkg;
  // Register storage indices
  typedef enum logic [3:0] {
    MPC_I_OSC, MPC_I_BALUN, MPC_I_LIN, MPC_I_MODA, MPC_I_NULL,
    MPC_I_PUMP, MPC_I_DITHA, MPC_I_DITHV, MPC_I_BAND, MPC_I_INT
  } mpc_idx_e;

  // Whole module state, registered as one word
  typedef struct packed {
    logic [9:0][15:0] regs; // Register file
    logic [1:0] sclk_s;     // Serial clock synchroniser
    logic [1:0] cs_s;       // Chip select synchroniser
    logic [1:0] sdi_s;      // Data input synchroniser
    logic sclk_p;           // Previous synchronised clock
    logic [4:0] cnt;        // Bit position in frame
    logic rd;               // Frame is a read
    logic [6:0] addr;       // Frame address
    logic [15:0] shift;     // Data shift register
    logic sdo;              // Serial output bit
    logic oe;               // Output enable
  } mpc_state_s;

  // Decoded fields toward the analog circuits
  typedef struct packed {
    logic [2:0] osc_core_select;
    logic [3:0] balun_out_cap;
    logic [3:0] balun_in_cap;
    logic [6:0] linearizer_res_select;
    logic [5:0] linearizer_cap_select;
    logic [2:0] modulator_bleed_current;
    logic [1:0] q_polarity_switch;
    logic [1:0] i_polarity_switch;
    logic [3:0] q_sideband_null;
    logic [3:0] i_sideband_null;
    logic [7:0] i_carrier_null;
    logic [7:0] q_carrier_null;
    logic [1:0] antibacklash_delay;
    logic [2:0] pump_control;
    logic [1:0] detector_edge_select;
    logic dither_enable;
    logic [1:0] dither_magnitude;
    logic dither_value_bit;
    logic [15:0] dither_value;
    logic [1:0] tuning_voltage_source;
    logic osc_band_source;
    logic [6:0] osc_band_select;
    logic [4:0] internal_set_hi;
    logic [8:0] internal_set_lo;
  } mpc_cfg_s;
endpackage : mpc_pkg
`default_nettype wire

// ==== verification/mpc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpc_host #(
  parameter int HALF = 6 // Serial clock half period, in system clocks
) (
  // System clock
  input wire logic clk_in,
  // Resolved serial data line
  input wire logic sdio_in,
  // Serial port drive
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdo_out,
  output logic sdo_en_out
);
  // Idle bus: clock parked low, chip deselected, data released
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdo_out = 1'b0;
    sdo_en_out = 1'b0;
  end

  // One frame, MSB first: read flag, address, data word.
  // A count below 24 lifts the select early to abort the frame.
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [15:0] d, input int nb,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 16'h0000;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (HALF) @(negedge clk_in);
    for (int i = 23; i >= 24 - nb; i--) begin
      sclk_out = 1'b0;
      // Let go of the line while the device answers a read
      sdo_en_out = !(rd && i < 16);
      sdo_out = f[i];
      // Half period of six clocks leaves the slow side time to settle
      repeat (HALF) @(negedge clk_in);
      // Read bits are taken just before the rising edge
      if (rd && i < 16) begin
        q[i] = sdio_in;
      end
      sclk_out = 1'b1;
      repeat (HALF) @(negedge clk_in);
    end
    // Deselect first, then park the clock low
    cs_n_out = 1'b1;
    sdo_en_out = 1'b0;
    repeat (HALF) @(negedge clk_in);
    sclk_out = 1'b0;
    repeat (HALF) @(negedge clk_in);
  endtask : xfer
endmodule : mpc_host
`default_nettype wire

// ==== verification/test_mpc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_mpc_regs;
  import mpc_pkg::*;
  // Bench clock, reset and enable
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  // Serial wires between host model and device
  logic sclk, cs_n, h_out, h_en, dev_out, dev_oe, sdio_w;
  logic idle_pat = 1'b0;
  mpc_cfg_s cfg;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // Reference map: address, reset value, writable bits, current value
  logic [6:0] adr [10] = '{7'h22, 7'h30, 7'h31, 7'h32, 7'h33, 7'h40,
                           7'h42, 7'h43, 7'h45, 7'h49};
  logic [15:0] rst [10] = '{16'h0003, 16'h0000, 16'h1101, 16'h0900,
    16'h0000, 16'h0010, 16'h000E, 16'h0000, 16'h0000, 16'h16BD};
  logic [15:0] msk [10] = '{16'h0007, 16'h00FF, 16'h1FFF, 16'h7FFF,
    16'hFFFF, 16'h007F, 16'h000F, 16'hFFFF, 16'h03FF, 16'h3FFF};
  logic [15:0] mdl [10];

  // 50 MHz clock
  always #10 clk = ~clk;
  // Undriven line toggles every cycle so a stale bit never passes
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign sdio_w = dev_oe ? dev_out : (h_en ? h_out : idle_pat);

  // Device under test
  mpc_regs i_mpc_regs (.clk_in(clk), .srst_in(srst), .ce_in(ce),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .sdio_in(sdio_w),
    .sdio_out(dev_out), .sdio_oe_out(dev_oe), .cfg_out(cfg));
  // Host controller model
  mpc_host i_mpc_host (.clk_in(clk), .sdio_in(sdio_w), .sclk_out(sclk),
    .cs_n_out(cs_n), .sdo_out(h_out), .sdo_en_out(h_en));

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Write a register and update the reference
  task automatic wr(input int k, input logic [15:0] d);
    logic [15:0] q;
    i_mpc_host.xfer(1'b0, adr[k], d, 24, q);
    mdl[k] = d & msk[k];
  endtask : wr

  // Read a register and compare against the reference
  task automatic rd(input int k);
    logic [15:0] q;
    i_mpc_host.xfer(1'b1, adr[k], 16'h0000, 24, q);
    chk($sformatf("reg_%h", adr[k]), mdl[k], q);
  endtask : rd

  // Read back the whole map
  task automatic rd_all;
    for (int k = 0; k < 10; k++) begin
      rd(k);
    end
  endtask : rd_all

  // Synchronous reset for ten cycles, then let synchronisers settle
  task automatic do_reset;
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    mdl = rst;
    repeat (3) @(negedge clk);
  endtask : do_reset

  // Decoded fields must be slices of the reference registers
  task automatic chk_cfg;
    chk("core", mdl[0][2:0], cfg.osc_core_select);
    chk("bal_out", mdl[1][7:4], cfg.balun_out_cap);
    chk("bal_in", mdl[1][3:0], cfg.balun_in_cap);
    chk("lin_res", mdl[2][12:6], cfg.linearizer_res_select);
    chk("lin_cap", mdl[2][5:0], cfg.linearizer_cap_select);
    chk("q_pol", mdl[3][11:10], cfg.q_polarity_switch);
    chk("i_pol", mdl[3][9:8], cfg.i_polarity_switch);
    chk("q_side", mdl[3][7:4], cfg.q_sideband_null);
    chk("i_side", mdl[3][3:0], cfg.i_sideband_null);
    chk("i_car", mdl[4][15:8], cfg.i_carrier_null);
    chk("q_car", mdl[4][7:0], cfg.q_carrier_null);
    chk("pump", mdl[5][4:2], cfg.pump_control);
    chk("edge", mdl[5][1:0], cfg.detector_edge_select);
    chk("tune", mdl[8][9:8], cfg.tuning_voltage_source);
    chk("int_hi", mdl[9][13:9], cfg.internal_set_hi);
    chk("int_lo", mdl[9][8:0], cfg.internal_set_lo);
    chk("dither_magnitude", mdl[6][2:1], cfg.dither_magnitude);
    chk("dither_value", mdl[7], cfg.dither_value);
    chk("bleed", mdl[3][14:12], cfg.modulator_bleed_current);
    chk("abl", mdl[5][6:5], cfg.antibacklash_delay);
    chk("dither_enable", mdl[6][3], cfg.dither_enable);
    chk("dith_bit", mdl[6][0], cfg.dither_value_bit);
    chk("band_src", mdl[8][7], cfg.osc_band_source);
    chk("band_sel", mdl[8][6:0], cfg.osc_band_select);
  endtask : chk_cfg

  // Print counts and verdict, then stop
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Hang guard: about 42k cycles expected
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      $display("mismatch timeout expected %0d seen %0d", 59999, cycles);
      end_sim();
    end
  end

  // Main sequence
  initial begin
    logic [15:0] q;
    logic [15:0] d;
    void'($urandom(18));
    do_reset();
    rd_all();
    chk_cfg();
    // Every listed code of core, pump, edge, polarity and tuning source
    for (int c = 0; c < 5; c++) begin
      wr(0, 16'(c));
      wr(5, 16'((c << 2) | (c % 4)));
      wr(3, c[0] ? 16'h0600 : 16'h0900);
      wr(8, c[0] ? 16'h0100 : 16'h0000);
      chk_cfg();
    end
    // All ones, all zeros, then random words across the whole map
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 10; k++) begin
        d = (r == 0) ? 16'hFFFF : (r == 1) ? 16'h0000 : 16'($urandom);
        wr(k, d);
      end
      rd_all();
      chk_cfg();
    end
    // Unmapped address: write ignored, read gives zero
    i_mpc_host.xfer(1'b0, 7'h7F, 16'hFFFF, 24, q);
    i_mpc_host.xfer(1'b1, 7'h7F, 16'h0000, 24, q);
    chk("unmapped", 16'h0000, q);
    rd_all();
    // Frame cut short after 20 bits must not commit
    i_mpc_host.xfer(1'b0, adr[7], ~mdl[7], 20, q);
    rd(7);
    // Clock enable low freezes the port, so a whole frame is lost
    ce = 1'b0;
    i_mpc_host.xfer(1'b0, adr[1], ~mdl[1], 24, q);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    rd(1);
    chk_cfg();
    // Reset in mid-run restores every reset value
    wr(2, 16'h0ABC);
    wr(6, 16'h0001);
    do_reset();
    rd_all();
    chk_cfg();
    end_sim();
  end
endmodule : test_mpc_regs
`default_nettype wire
